// *** rtl/uil_pkg.sv ***
// Shared constants, field layouts and types of the UART interrupt and line format block
package uil_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_LFC = 8'h04;
  localparam logic [7:0] OFS_FSC = 8'h08;
  localparam logic [7:0] OFS_DIV = 8'h0C;
  localparam int ADDR_W = 8;

  // Line format control field positions
  localparam int LFC_DLAB = 7;
  localparam int LFC_BRK = 6;
  localparam int LFC_FORCE = 5;
  localparam int LFC_EVEN = 4;
  localparam int LFC_PEN = 3;
  localparam int LFC_STOP = 2;
  localparam logic [7:0] LFC_RESET = 8'h00;

  // FIFO setup control: only the enable bit is kept
  localparam int FSC_EN = 0;
  localparam logic FSC_RESET = 1'b0;

  // Interrupt identify codes, bits 5:0
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_RXDATA = 6'h04;
  localparam logic [5:0] CODE_RXTMO = 6'h0C;
  localparam logic [5:0] CODE_THR = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_NONE = 6'h01;
  localparam logic [1:0] IDENT_FIFO_ON = 2'h3;
  localparam logic [1:0] IDENT_FIFO_OFF = 2'h0;

  // Baud divisor: half-bit clocks
  localparam logic [15:0] DIV_RESET = 16'h0001;

  // Stop length in half-bit ticks
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;
  localparam logic [2:0] HALVES_PER_BIT = 3'h2;
  localparam logic [3:0] MIN_BITS = 4'h5;

  // Character format as it travels between blocks
  typedef struct packed {
    logic dlab;
    logic brk;
    logic force_par;
    logic even;
    logic pen;
    logic stop2;
    logic [1:0] len;
  } uil_lfc_t;

  // Pending interrupt sources, highest priority first
  typedef struct packed {
    logic line;
    logic rxtmo;
    logic rxdata;
    logic thr;
    logic modem;
  } uil_src_t;

  // Transmitter states
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } uil_tx_st_t;
endpackage

// *** rtl/uil_parity.sv ***
// Parity bit generator for one character under the programmed format
`timescale 1ns/1ns
module uil_parity (
  input wire logic [7:0] data,
  input wire uil_pkg::uil_lfc_t fmt,
  output logic par
);
  logic [7:0] mask;
  logic ones_odd;

  // Bits above the character length do not count
  always_comb begin
    mask = 8'h1F;
    case (fmt.len)
      2'h1: mask = 8'h3F;
      2'h2: mask = 8'h7F;
      2'h3: mask = 8'hFF;
      default: mask = 8'h1F;
    endcase
  end

  assign ones_odd = ^(data & mask);

  // Forced parity is the inverse of the even bit; odd parity makes the total odd
  always_comb begin
    if (fmt.force_par) begin
      par = ~fmt.even;
    end else if (fmt.even) begin
      par = ones_odd;
    end else begin
      par = ~ones_odd;
    end
  end
endmodule // uil_parity

// *** rtl/uil_top.sv ***
// UART interrupt identification, line format control and a format-driven transmitter
// What this block does
// - Four priority levels; identify read returns highest pending code.
// - Lower sources stay hidden while a higher one is pending.
// - Identify read clears only the reported source; others show later.
// - Line status: level 1, code bits 2 and 1 set.
// - Receive data and time-out: level 2, bit 2; time-out adds bit 3.
// - Transmit holding empty: level 3, only bit 1 set.
// - Modem status: level 4, bits 5 to 0 zero.
// - Identify bits 7:6 are 1 with FIFOs enabled, else 0.
// - Identify bits 5:4 always read zero.
// - Identify bit 0 is 0 while pending, 1 when idle.
// - Format bit 7 opens divisor latch and enhanced mode access.
// - Format bit 6 holds serial output low until cleared.
// - Format bit 3 adds parity on transmit and checks on receive.
// - Bit 4 picks odd (0) or even (1) parity.
// - Bit 5 forces parity: 1 when bit 4 clear, 0 when set.
// - Bit 2 gives 1.5 stop bits for 5-bit, else 2.
// - Bits 1:0 choose 5, 6, 7 or 8 data bits.
// - FIFO setup enable bit turns both FIFOs on; default off.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module uil_top #(
  parameter int DIV_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_status_evt,
  input wire logic rx_timeout_evt,
  input wire logic modem_evt,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_par_bit,
  output logic rx_par_err,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic tx_serial,
  output uil_pkg::uil_lfc_t line_format,
  output logic fifo_enable,
  output logic enh_access
);
  // Divisor width must hold the reset value and fit the data bus
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div_w
    $error("uil_top: DIV_W must be 2 to 16");
  end

  uil_pkg::uil_lfc_t lfc_ff;
  logic fsc_en_ff;
  logic [DIV_W-1:0] div_ff;
  uil_pkg::uil_src_t pend_ff;
  uil_pkg::uil_src_t clr;
  uil_pkg::uil_src_t top_src;
  uil_pkg::uil_src_t held_src_ff;
  logic [7:0] ident;
  logic [5:0] code;
  logic [31:0] nxt_prdata;
  logic [31:0] prdata_ff;
  logic map_hit;
  logic err_ff;
  logic setup;
  logic access;
  logic wr;
  logic rd_ident;
  logic par_err;
  logic rx_par_exp;
  logic thr_evt;

  // APB phases; the slave never waits
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = access & err_ff;

  // Priority pick: only the winner survives, lower ones stay hidden
  always_comb begin
    top_src = '0;
    if (pend_ff.line) begin
      top_src.line = 1'b1;
    end else if (pend_ff.rxtmo) begin
      top_src.rxtmo = 1'b1;
    end else if (pend_ff.rxdata) begin
      top_src.rxdata = 1'b1;
    end else if (pend_ff.thr) begin
      top_src.thr = 1'b1;
    end else if (pend_ff.modem) begin
      top_src.modem = 1'b1;
    end
  end

  // Code for the winning source
  always_comb begin
    code = uil_pkg::CODE_NONE;
    if (top_src.line) begin
      code = uil_pkg::CODE_LINE;
    end else if (top_src.rxtmo) begin
      code = uil_pkg::CODE_RXTMO;
    end else if (top_src.rxdata) begin
      code = uil_pkg::CODE_RXDATA;
    end else if (top_src.thr) begin
      code = uil_pkg::CODE_THR;
    end else if (top_src.modem) begin
      code = uil_pkg::CODE_MODEM;
    end
  end

  // Top bits mirror the FIFO enable; reserved bits 5:4 come from the code table as zero
  assign ident[7:6] = fsc_en_ff ? uil_pkg::IDENT_FIFO_ON : uil_pkg::IDENT_FIFO_OFF;
  assign ident[5:0] = code;

  // Address decode
  always_comb begin
    map_hit = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      uil_pkg::OFS_IDENT: nxt_prdata = {24'h000000, ident};
      uil_pkg::OFS_LFC: nxt_prdata = {24'h000000, lfc_ff};
      uil_pkg::OFS_FSC: nxt_prdata = {31'h0000_0000, fsc_en_ff};
      uil_pkg::OFS_DIV: begin
        // Divisor hidden unless the latch is open
        if (lfc_ff.dlab) begin
          nxt_prdata[DIV_W-1:0] = div_ff;
        end
      end
      default: map_hit = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      err_ff <= ~map_hit;
    end
  end

  // Source reported at setup is the one the read clears, even if a higher one lands meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_src_ff <= '0;
    end else if (setup) begin
      held_src_ff <= top_src;
    end
  end

  assign rd_ident = access & ~pwrite & (paddr == uil_pkg::OFS_IDENT);
  assign clr = rd_ident ? held_src_ff : '0;

  // Sticky pending flags; a new event in the clear cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= '0;
    end else begin
      pend_ff.line <= (pend_ff.line & ~clr.line) | line_status_evt | par_err;
      pend_ff.rxtmo <= (pend_ff.rxtmo & ~clr.rxtmo) | rx_timeout_evt;
      pend_ff.rxdata <= (pend_ff.rxdata & ~clr.rxdata) | rx_char_valid;
      pend_ff.thr <= (pend_ff.thr & ~clr.thr) | thr_evt;
      pend_ff.modem <= (pend_ff.modem & ~clr.modem) | modem_evt;
    end
  end

  // Format register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfc_ff <= uil_pkg::LFC_RESET;
    end else if (wr && paddr == uil_pkg::OFS_LFC) begin
      lfc_ff <= pwdata[7:0];
    end
  end

  // FIFO enable bit; other setup bits belong to the FIFO datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsc_en_ff <= uil_pkg::FSC_RESET;
    end else if (wr && paddr == uil_pkg::OFS_FSC) begin
      fsc_en_ff <= pwdata[uil_pkg::FSC_EN];
    end
  end

  // Divisor writes ignored while the latch is closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= DIV_W'(uil_pkg::DIV_RESET);
    end else if (wr && paddr == uil_pkg::OFS_DIV && lfc_ff.dlab) begin
      div_ff <= pwdata[DIV_W-1:0];
    end
  end

  assign line_format = lfc_ff;
  assign fifo_enable = fsc_en_ff;
  assign enh_access = lfc_ff.dlab;

  // Receive parity check; the remote must use the same format
  uil_parity u_rx_par (
    .data(rx_char),
    .fmt(lfc_ff),
    .par(rx_par_exp)
  );
  assign par_err = rx_char_valid & lfc_ff.pen & (rx_par_bit != rx_par_exp);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_par_err <= 1'b0;
    end else begin
      rx_par_err <= par_err;
    end
  end

  // Transmitter
  uil_pkg::uil_tx_st_t st_ff;
  logic [DIV_W-1:0] div_cnt_ff;
  logic [DIV_W-1:0] div_m1;
  logic [2:0] half_ff;
  logic [2:0] need;
  logic [2:0] stop_halves;
  logic [3:0] bits;
  logic [2:0] bidx_ff;
  logic [7:0] sh_ff;
  logic par_ff;
  logic tx_par;
  logic tick;
  logic elem_end;
  logic accept;
  logic line_ff;

  // Divisor of zero runs as one so the transmitter never stalls
  assign div_m1 = (div_ff == '0) ? '0 : div_ff - DIV_W'(1);
  assign tick = (st_ff != uil_pkg::TX_IDLE) && (div_cnt_ff == '0);
  assign accept = tx_valid & tx_ready;
  assign tx_ready = (st_ff == uil_pkg::TX_IDLE);
  assign bits = uil_pkg::MIN_BITS + {2'h0, lfc_ff.len};

  // Stop length in half-bit ticks
  always_comb begin
    stop_halves = uil_pkg::STOP_ONE;
    if (lfc_ff.stop2) begin
      stop_halves = (lfc_ff.len == 2'h0) ? uil_pkg::STOP_ONE_HALF : uil_pkg::STOP_TWO;
    end
  end

  assign need = (st_ff == uil_pkg::TX_STOP) ? stop_halves : uil_pkg::HALVES_PER_BIT;
  assign elem_end = tick && (half_ff == need - 3'h1);

  uil_parity u_tx_par (
    .data(tx_data),
    .fmt(lfc_ff),
    .par(tx_par)
  );

  // Half-bit timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= '0;
    end else if (accept || tick) begin
      div_cnt_ff <= div_m1;
    end else if (st_ff != uil_pkg::TX_IDLE) begin
      div_cnt_ff <= div_cnt_ff - DIV_W'(1);
    end
  end

  // Half ticks within the current element
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 3'h0;
    end else if (accept || elem_end) begin
      half_ff <= 3'h0;
    end else if (tick) begin
      half_ff <= half_ff + 3'h1;
    end
  end

  // Character and its parity captured when taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ff <= 8'h00;
      par_ff <= 1'b0;
    end else if (accept) begin
      sh_ff <= tx_data;
      par_ff <= tx_par;
    end
  end

  // Frame sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= uil_pkg::TX_IDLE;
      bidx_ff <= 3'h0;
    end else begin
      case (st_ff)
        uil_pkg::TX_IDLE: begin
          if (accept) begin
            st_ff <= uil_pkg::TX_START;
            bidx_ff <= 3'h0;
          end
        end
        uil_pkg::TX_START: begin
          if (elem_end) begin
            st_ff <= uil_pkg::TX_DATA;
          end
        end
        uil_pkg::TX_DATA: begin
          if (elem_end) begin
            if ({1'b0, bidx_ff} == bits - 4'h1) begin
              st_ff <= lfc_ff.pen ? uil_pkg::TX_PAR : uil_pkg::TX_STOP;
            end else begin
              bidx_ff <= bidx_ff + 3'h1;
            end
          end
        end
        uil_pkg::TX_PAR: begin
          if (elem_end) begin
            st_ff <= uil_pkg::TX_STOP;
          end
        end
        uil_pkg::TX_STOP: begin
          if (elem_end) begin
            st_ff <= uil_pkg::TX_IDLE;
          end
        end
        default: st_ff <= uil_pkg::TX_IDLE;
      endcase
    end
  end

  // Holding register empties when a frame completes
  assign thr_evt = (st_ff == uil_pkg::TX_STOP) && elem_end;

  // Line level; break overrides everything and frames keep running underneath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ff <= 1'b1;
    end else if (lfc_ff.brk) begin
      line_ff <= 1'b0;
    end else begin
      case (st_ff)
        uil_pkg::TX_START: line_ff <= 1'b0;
        uil_pkg::TX_DATA: line_ff <= sh_ff[bidx_ff];
        uil_pkg::TX_PAR: line_ff <= par_ff;
        default: line_ff <= 1'b1;
      endcase
    end
  end

  assign tx_serial = line_ff;
endmodule // uil_top

// *** testbench/uil_top_props.sv ***
// Port-level checks on the interrupt identify and line format block
`timescale 1ns/1ns
module uil_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic line_status_evt,
  input wire logic rx_char_valid,
  input wire logic rx_par_bit,
  input wire logic rx_par_err,
  input wire logic tx_serial,
  input wire uil_pkg::uil_lfc_t line_format,
  input wire logic fifo_enable,
  input wire logic enh_access
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle of an identify read; its data shows in the access cycle
  sequence id_setup;
    psel && !penable && !pwrite && paddr == uil_pkg::OFS_IDENT;
  endsequence
  sequence line_then_read;
    line_status_evt ##1 id_setup;
  endsequence
  a_line_wins: assert property (line_then_read |=> prdata[5:0] == 6'h06)
    else $error("line status not reported first");
  a_rsvd_zero: assert property (id_setup |=> prdata[5:4] == 2'h0)
    else $error("reserved identify bits set");
  a_fifo_bits: assert property (id_setup |=> prdata[7:6] == {2{fifo_enable}})
    else $error("identify bits 7:6 disagree with fifo enable");
  a_idle_bit: assert property (id_setup |=> !prdata[0] || prdata[3:1] == 3'h0)
    else $error("idle flag with a source code");
  a_brk_low: assert property (line_format.brk |=> !tx_serial)
    else $error("serial output not held low in break");
  // A format write must land whole and bit 7 must show as the access enable
  a_enh_dlab: assert property (psel && penable && pwrite && paddr == uil_pkg::OFS_LFC
    |=> line_format == $past(pwdata[7:0]) && enh_access == line_format.dlab)
    else $error("format write not taken or bit 7 not shown as access enable");
  a_force_err: assert property (rx_char_valid && line_format.pen
    && line_format.force_par && rx_par_bit == line_format.even |=> rx_par_err)
    else $error("forced parity mismatch not flagged");
  a_nopar_quiet: assert property (rx_char_valid && !line_format.pen |=> !rx_par_err)
    else $error("parity error without parity");
endmodule // uil_top_props

bind uil_top uil_top_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .line_status_evt(line_status_evt), .rx_char_valid(rx_char_valid), .rx_par_bit(rx_par_bit),
  .rx_par_err(rx_par_err), .tx_serial(tx_serial), .line_format(line_format),
  .fifo_enable(fifo_enable), .enh_access(enh_access));

// *** testbench/uil_remote_end.sv ***
// Far-end serial partner: captures sent frames, strobes received characters
`timescale 1ns/1ns
module uil_remote_end (
  input wire logic pclk,
  input wire logic tx_line,
  input wire uil_pkg::uil_lfc_t fmt,
  output logic [7:0] cap_data,
  output logic cap_par,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_par
);
  // Samples each bit in its second clock; assumes the divisor stays at one
  initial begin
    cap_data = 8'h00;
    cap_par = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_par = 1'b0;
    forever begin
      @(posedge pclk);
      if (tx_line === 1'b0) begin
        @(posedge pclk);
        cap_data = 8'h00;
        for (int i = 0; i < 5 + fmt.len; i++) begin
          repeat (2) @(posedge pclk);
          cap_data[i] = tx_line;
        end
        if (fmt.pen) begin
          repeat (2) @(posedge pclk);
          cap_par = tx_line;
        end
        repeat (2) @(posedge pclk);
      end
    end
  end

  // One-cycle strobe; lines carry the inverse between strobes so stale data is not trusted
  task automatic send(input logic [7:0] d, input logic p);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_par <= p;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_par <= ~p;
  endtask
endmodule // uil_remote_end

// *** testbench/test_uil_top.sv ***
// Self-checking bench for the interrupt identify and line format block
`timescale 1ns/1ns
module test_uil_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rx_char, tx_data, cap_data, d;
  logic [31:0] pwdata, prdata, rd;
  logic line_status_evt, rx_timeout_evt, modem_evt, rx_char_valid, rx_par_bit, rx_par_err;
  logic tx_valid, tx_ready, tx_serial, fifo_enable, enh_access, cap_par;
  uil_pkg::uil_lfc_t line_format;
  int err_count, total_checks, n, m, len0;
  logic [7:0] fmts [10] = '{8'h00, 8'h04, 8'h03, 8'h07, 8'h0B, 8'h1B, 8'h2B, 8'h3B, 8'h19, 8'h0E};
  logic [5:0] codes [6] = '{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h01};
  logic [7:0] pf [5] = '{8'h1B, 8'h1B, 8'h2B, 8'h3B, 8'h08};
  logic pb [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic pe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  uil_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_status_evt(line_status_evt), .rx_timeout_evt(rx_timeout_evt),
    .modem_evt(modem_evt), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_par_bit(rx_par_bit), .rx_par_err(rx_par_err), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_serial(tx_serial),
    .line_format(line_format), .fifo_enable(fifo_enable), .enh_access(enh_access));
  uil_remote_end remote_u (.pclk(pclk), .tx_line(tx_serial), .fmt(line_format),
    .cap_data(cap_data), .cap_par(cap_par), .rx_valid(rx_char_valid), .rx_data(rx_char),
    .rx_par(rx_par_bit));

  // Comparison, verdict and bus helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(0, 1);
    if (n >= 50) complete_run();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Frame length is counted from acceptance until the sender is ready again
  task automatic tx_send(input logic [7:0] v);
    @(posedge pclk);
    tx_valid <= 1'b1;
    tx_data <= v;
    @(posedge pclk);
    tx_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tx_ready !== 1'b1 && n < 200);
    if (n >= 200) chk(0, 1);
    if (n >= 200) complete_run();
  endtask
  function automatic logic exp_par(input logic [7:0] v, input logic [7:0] f);
    logic [7:0] w;
    w = v & (8'hFF >> (3 - f[1:0]));
    if (f[5]) return !f[4];
    return f[4] ? ^w : ~^w;
  endfunction

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {line_status_evt, rx_timeout_evt, modem_evt, tx_valid, tx_data} = '0;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    chk(rd, 32'h01);
    apb(1, 8'h00, 32'hFF);
    apb(0, 8'h00, 0);
    chk(rd, 32'h01);
    apb(0, 8'h04, 0);
    chk(rd, 32'h00);
    apb(0, 8'h10, 0);
    chk(err, 1'b1);
    $display("done: reset");
    for (int i = 0; i < 10; i++) begin
      d = 8'hA6 + 8'(i);
      apb(1, 8'h04, {24'h0, fmts[i]});
      tx_send(d);
      m = 2 * (6 + fmts[i][1:0] + fmts[i][3]) + (fmts[i][2] ? (fmts[i][1:0] == 0 ? 3 : 4) : 2);
      if (i == 0) len0 = n - m;
      chk(n - m, len0);
      chk(cap_data, d & (8'hFF >> (3 - fmts[i][1:0])));
      if (fmts[i][3]) chk(cap_par, exp_par(d, fmts[i]));
    end
    $display("done: format");
    apb(1, 8'h04, 32'h03);
    @(posedge pclk);
    {line_status_evt, rx_timeout_evt, modem_evt} <= 3'h7;
    // Identify read set up right behind the pulse, so the line-first check has work
    fork
      apb(0, 8'h00, 0);
      begin
        @(posedge pclk);
        {line_status_evt, rx_timeout_evt, modem_evt} <= 3'h0;
      end
    join
    chk(rd, {26'h0, codes[0]});
    remote_u.send(8'h5A, 1'b0);
    @(posedge pclk);
    chk(rx_par_err, 1'b0);
    for (int k = 1; k < 6; k++) begin
      apb(0, 8'h00, 0);
      chk(rd, {26'h0, codes[k]});
    end
    $display("done: priority");
    foreach (pf[k]) begin
      apb(1, 8'h04, {24'h0, pf[k]});
      remote_u.send(8'h01, pb[k]);
      @(posedge pclk);
      chk(rx_par_err, pe[k]);
    end
    $display("done: parity");
    // Parity errors above left line status pending, behind it the received data
    apb(1, 8'h08, 32'h1);
    @(posedge pclk);
    chk(fifo_enable, 1'b1);
    apb(0, 8'h00, 0);
    chk(rd, 32'hC6);
    apb(0, 8'h00, 0);
    chk(rd, 32'hC4);
    apb(0, 8'h00, 0);
    chk(rd, 32'hC1);
    apb(1, 8'h08, 32'h0);
    apb(0, 8'h00, 0);
    chk(rd, 32'h01);
    $display("done: fifo");
    apb(0, 8'h0C, 0);
    chk(rd, 32'h0);
    apb(1, 8'h0C, 32'h5);
    apb(1, 8'h04, 32'h80);
    @(posedge pclk);
    chk(enh_access, 1'b1);
    chk(line_format, 32'h80);
    apb(0, 8'h0C, 0);
    chk(rd, 32'h1);
    apb(1, 8'h0C, 32'h3);
    apb(0, 8'h0C, 0);
    chk(rd, 32'h3);
    apb(1, 8'h0C, 32'h1);
    apb(1, 8'h04, 32'h40);
    repeat (3) @(posedge pclk);
    chk(tx_serial, 1'b0);
    apb(1, 8'h04, 32'h00);
    repeat (3) @(posedge pclk);
    chk(tx_serial, 1'b1);
    $display("done: latch and break");
    complete_run();
  end
endmodule // test_uil_top
